// ===== verilog/fdt_cfg.svh
`ifndef FDT_CFG_SVH
`define FDT_CFG_SVH

// register offsets
`define FDT_OFS_DITHER_CTRL   12'h40c
`define FDT_OFS_TABLE_INDEX   12'h418
`define FDT_OFS_TABLE_DATA    12'h41c
`define FDT_OFS_DITHER_RAM    12'h424

// field positions
`define FDT_DC_ENABLE_BIT     0
`define FDT_DC_DBITS_LSB      1
`define FDT_DC_FBITS_LSB      4
`define FDT_DC_SRC_BIT        12
`define FDT_IDX_LSB           0
`define FDT_SEL_LSB           8
`define FDT_RAMSEL_LSB        6

// reset values
`define FDT_DITHER_CTRL_RST   32'h0000_0000
`define FDT_TABLE_INDEX_RST   32'h0000_0000
`define FDT_DITHER_RAM_RST    32'h0000_0000

`endif

// ===== verilog/fdt_pkg.sv
package fdt_pkg;

  typedef enum logic [1:0] {
    FDT_SEL_ALL,
    FDT_SEL_RED,
    FDT_SEL_GREEN,
    FDT_SEL_BLUE
  } fdt_colour_sel_t;

  typedef enum {
    FDT_OUT_IDLE,
    FDT_OUT_FULL
  } fdt_out_state_t;

endpackage : fdt_pkg

// ===== verilog/fdt_fifo.sv
`timescale 1ns/1ps
module fdt_fifo #(
  parameter int WIDTH = 20,
  parameter int DEPTH = 16
) (
  // clock and reset
  input  wire logic             clock,
  input  wire logic             rst_n,
  // fill side
  input  wire logic             in_valid,
  output logic                  in_ready,
  input  wire logic [WIDTH-1:0] in_data,
  // drain side
  output logic                  out_valid,
  input  wire logic             out_ready,
  output logic [WIDTH-1:0]      out_data
);
  localparam int AW = $clog2(DEPTH);

  logic [WIDTH-1:0] store [DEPTH];
  logic [AW-1:0]    wr_ptr;
  logic [AW-1:0]    rd_ptr;
  logic [AW:0]      count;
  logic [AW-1:0]    next_wr_ptr;
  logic [AW-1:0]    next_rd_ptr;
  logic [AW:0]      next_count;
  logic             push;
  logic             pop;

  always_comb begin
    push        = in_valid && in_ready;
    pop         = out_valid && out_ready;
    next_wr_ptr = push ? AW'(wr_ptr + 1'b1) : wr_ptr;
    next_rd_ptr = pop ? AW'(rd_ptr + 1'b1) : rd_ptr;
    next_count  = count;
    if (push && !pop) begin
      next_count = (AW+1)'(count + 1'b1);
    end else if (pop && !push) begin
      next_count = (AW+1)'(count - 1'b1);
    end
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      wr_ptr    <= '0;
      rd_ptr    <= '0;
      count     <= '0;
      in_ready  <= 1'b1;
      out_valid <= 1'b0;
    end else begin
      wr_ptr    <= next_wr_ptr;
      rd_ptr    <= next_rd_ptr;
      count     <= next_count;
      in_ready  <= next_count < (AW+1)'(DEPTH);
      out_valid <= next_count != '0;
    end
  end

  // storage has no reset; only written entries are ever presented
  always_ff @(posedge clock) begin
    if (push) begin
      store[wr_ptr] <= in_data;
    end
  end

  always_ff @(posedge clock) begin
    out_data <= store[next_rd_ptr];
    if (push && (next_rd_ptr == wr_ptr)) begin
      out_data <= in_data;
    end
  end

endmodule : fdt_fifo

// ===== verilog/fdt_top.sv
// Function
// R1: three separate colour modulation tables, each 32 rows of 64 bits
// R2: select 00 writes all tables reading red; 01 red; 10 green
// R3: select code 11 addresses blue alone for reads and writes
// R4: table index bits 5:0 auto-increment after each data access
// R5: even index is low half of a row, odd index the upper half
// R6: index 00h is row 0 low half, 01h row 0 high half
// R7: data register moves one half-row of the selected table at the index
// R8: tables stay accessible regardless of panel power state
// R9: dithering acts only when control bit 0 is set
// R10: frame modulation is always applied, never bypassed
// R11: software keeps modulation and dither bit-count fields matching
// R12: control bit 12 low selects the built-in pattern store; the code uses the built-in store whatever bit 12 holds
// R13: pattern RAM low-power when source bit 0 and RAM select 00
// R14: pattern bit one lowers one intensity step, zero passes through
// R15: low bits choose the pattern; all ones pass every pixel unchanged
// R16: two-bit 2x2 group: 00 lowers three pixels, one fewer per step
// R17: unmarked position keeps level first, then smaller labels follow
// R18: built-in patterns cover one to five dither bits
// R19: pattern bit picked by column and line modulo 8, counters restart per frame
// R20: top bits pick a 64-bit word; its ones set lit frames of 64
// R21: both randomisation shift registers restart at every frame
`timescale 1ns/1ps
`include "fdt_cfg.svh"
module fdt_top
  import fdt_pkg::*;
#(
  parameter int COMP_W     = 6,
  parameter int ROWS       = 32,
  parameter int FIFO_DEPTH = 16
) (
  // clock and reset
  input  wire logic              clock,
  input  wire logic              rst_n,
  // parallel configuration register port
  input  wire logic              reg_strobe,
  input  wire logic              reg_write,
  input  wire logic [11:0]       reg_addr,
  input  wire logic [31:0]       reg_wdata,
  output logic [31:0]            reg_rdata,
  output logic                   reg_rvalid,
  // incoming pixel stream
  input  wire logic              pix_valid,
  output logic                   pix_ready,
  input  wire logic              pix_frame_start,
  input  wire logic              pix_line_start,
  input  wire logic [COMP_W-1:0] pix_red,
  input  wire logic [COMP_W-1:0] pix_green,
  input  wire logic [COMP_W-1:0] pix_blue,
  // modulated output stream
  output logic                   out_valid,
  input  wire logic              out_ready,
  output logic                   out_red_on,
  output logic                   out_green_on,
  output logic                   out_blue_on,
  // pattern RAM power hint
  output logic                   dither_ram_low_power
);
  localparam int FW = 3 * COMP_W + 2;
  localparam int RW = $clog2(ROWS);

  // configuration state
  logic [31:0]     dither_ctrl;
  logic [1:0]      dither_ram_sel;
  logic [5:0]      modulation_table_index;
  fdt_colour_sel_t colour_table_select;
  logic [31:0]     next_dither_ctrl;
  logic [1:0]      next_dither_ram_sel;
  logic [5:0]      next_modulation_table_index;
  fdt_colour_sel_t next_colour_table_select;
  logic [31:0]     next_reg_rdata;
  logic            next_reg_rvalid;
  logic            next_ram_low_power;

  // frame modulation tables, one per colour
  logic [63:0] table_red   [ROWS];
  logic [63:0] table_green [ROWS];
  logic [63:0] table_blue  [ROWS];

  logic            data_access;
  logic            data_write;
  logic [RW-1:0]   acc_row;
  logic            acc_high;
  logic [63:0]     acc_word;

  // an 8x8 ordered threshold; its top n bits rank each tile position
  function automatic logic [5:0] fdt_rank(input logic [2:0] x, input logic [2:0] y,
                                          input logic [2:0] nbits);
    logic [5:0] full;
    logic [2:0] xy;
    xy   = x ^ y;
    full = {xy[0], y[0], xy[1], y[1], xy[2], y[2]};
    return 6'(full >> (3'd6 - nbits));                                            // R18
  endfunction : fdt_rank

  // row index for one component after the optional one-step lowering
  function automatic logic [RW-1:0] fdt_row(input logic [COMP_W-1:0] value,
                                            input logic              dith_on,
                                            input logic [2:0]        dbits,
                                            input logic [2:0]        x,
                                            input logic [2:0]        y);
    logic [COMP_W-1:0] low_mask;
    logic [COMP_W-1:0] upper;
    logic              lower;
    low_mask = COMP_W'((1 << dbits) - 1);
    upper    = dith_on ? COMP_W'(value >> dbits) : COMP_W'(value >> (COMP_W - RW));
    lower    = dith_on && ((value & low_mask) != low_mask) &&                     // R9 R15
               (COMP_W'(fdt_rank(x, y, dbits)) > (value & low_mask));              // R16 R17
    if (lower && upper != '0) begin                                                // R14
      upper = COMP_W'(upper - 1'b1);
    end
    return RW'(upper);                                                             // R20
  endfunction : fdt_row

  // register port: decode, data-port access and auto-increment
  always_comb begin
    next_dither_ctrl            = dither_ctrl;
    next_dither_ram_sel         = dither_ram_sel;
    next_modulation_table_index = modulation_table_index;
    next_colour_table_select    = colour_table_select;
    next_reg_rdata              = reg_rdata;
    next_reg_rvalid             = reg_strobe && !reg_write;
    data_access                 = reg_strobe && (reg_addr == `FDT_OFS_TABLE_DATA);
    data_write                  = data_access && reg_write;
    acc_row                     = RW'(modulation_table_index[5:1]);             // R5
    acc_high                    = modulation_table_index[0];                    // R5 R6
    case (colour_table_select)
      FDT_SEL_GREEN: acc_word = table_green[acc_row];
      FDT_SEL_BLUE:  acc_word = table_blue[acc_row];                            // R3
      default:       acc_word = table_red[acc_row];                             // R2
    endcase
    if (reg_strobe && reg_write) begin
      case (reg_addr)
        `FDT_OFS_DITHER_CTRL: next_dither_ctrl = reg_wdata;
        `FDT_OFS_DITHER_RAM:  next_dither_ram_sel = reg_wdata[`FDT_RAMSEL_LSB +: 2];
        `FDT_OFS_TABLE_INDEX: begin
          next_modulation_table_index = reg_wdata[`FDT_IDX_LSB +: 6];
          next_colour_table_select    = fdt_colour_sel_t'(reg_wdata[`FDT_SEL_LSB +: 2]);
        end
        default: ;
      endcase
    end else if (reg_strobe) begin
      case (reg_addr)
        `FDT_OFS_DITHER_CTRL: next_reg_rdata = dither_ctrl;
        `FDT_OFS_DITHER_RAM:  next_reg_rdata = {24'h0, dither_ram_sel, 6'h0};
        `FDT_OFS_TABLE_INDEX: next_reg_rdata = {22'h0, colour_table_select, 2'h0,
                                                modulation_table_index};
        `FDT_OFS_TABLE_DATA:  next_reg_rdata = acc_high ? acc_word[63:32]
                                                        : acc_word[31:0];      // R7
        default:              next_reg_rdata = 32'h0;
      endcase
    end
    if (data_access) begin
      next_modulation_table_index = 6'(modulation_table_index + 1'b1);        // R4
    end
    next_ram_low_power = !next_dither_ctrl[`FDT_DC_SRC_BIT] &&
                         (next_dither_ram_sel == 2'b00);                       // R13
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      dither_ctrl            <= `FDT_DITHER_CTRL_RST;
      dither_ram_sel         <= 2'(`FDT_DITHER_RAM_RST >> `FDT_RAMSEL_LSB);
      modulation_table_index <= 6'(`FDT_TABLE_INDEX_RST);
      colour_table_select    <= FDT_SEL_ALL;
      reg_rdata              <= 32'h0;
      reg_rvalid             <= 1'b0;
      dither_ram_low_power   <= 1'b1;
    end else begin
      dither_ctrl            <= next_dither_ctrl;
      dither_ram_sel         <= next_dither_ram_sel;
      modulation_table_index <= next_modulation_table_index;
      colour_table_select    <= next_colour_table_select;
      reg_rdata              <= next_reg_rdata;
      reg_rvalid             <= next_reg_rvalid;
      dither_ram_low_power   <= next_ram_low_power;
    end
  end

  // table writes need no panel power or pixel activity, only the clock  R8
  always_ff @(posedge clock) begin
    if (data_write) begin
      if (colour_table_select inside {FDT_SEL_ALL, FDT_SEL_RED}) begin       // R1 R2
        if (acc_high) table_red[acc_row][63:32] <= reg_wdata;                 // R7
        else          table_red[acc_row][31:0]  <= reg_wdata;
      end
      if (colour_table_select inside {FDT_SEL_ALL, FDT_SEL_GREEN}) begin     // R1 R2
        if (acc_high) table_green[acc_row][63:32] <= reg_wdata;
        else          table_green[acc_row][31:0]  <= reg_wdata;
      end
      if (colour_table_select inside {FDT_SEL_ALL, FDT_SEL_BLUE}) begin      // R1 R3
        if (acc_high) table_blue[acc_row][63:32] <= reg_wdata;
        else          table_blue[acc_row][31:0]  <= reg_wdata;
      end
    end
  end

  // pixel buffer in front of the pipeline
  logic          fifo_valid;
  logic          fifo_take;
  logic [FW-1:0] fifo_data;

  fdt_fifo #(
    .WIDTH (FW),
    .DEPTH (FIFO_DEPTH)
  ) u_fifo (
    .clock     (clock),
    .rst_n     (rst_n),
    .in_valid  (pix_valid),
    .in_ready  (pix_ready),
    .in_data   ({pix_frame_start, pix_line_start, pix_red, pix_green, pix_blue}),
    .out_valid (fifo_valid),
    .out_ready (fifo_take),
    .out_data  (fifo_data)
  );

  // pixel pipeline state
  fdt_out_state_t out_state;
  fdt_out_state_t next_out_state;
  logic [2:0]     col_cnt;
  logic [2:0]     line_cnt;
  logic [5:0]     frame_cnt;
  logic [14:0]    prs_pixel;
  logic [8:0]     prs_line;
  logic [2:0]     next_col_cnt;
  logic [2:0]     next_line_cnt;
  logic [5:0]     next_frame_cnt;
  logic [14:0]    next_prs_pixel;
  logic [8:0]     next_prs_line;
  logic           next_red_on;
  logic           next_green_on;
  logic           next_blue_on;
  logic           sof;
  logic           sol;
  logic [2:0]     px;
  logic [2:0]     py;
  logic [5:0]     phase;
  logic [5:0]     pos;
  logic           dith_on;
  logic [2:0]     dbits;

  always_comb begin
    sof            = fifo_data[FW-1];
    sol            = fifo_data[FW-2];
    dith_on        = dither_ctrl[`FDT_DC_ENABLE_BIT];
    // pattern store is the built-in one; software keeps fields in step  R11 R12
    dbits          = dither_ctrl[`FDT_DC_DBITS_LSB +: 3];
    fifo_take      = fifo_valid && (out_state == FDT_OUT_IDLE || out_ready);
    next_out_state = out_state;
    next_col_cnt   = col_cnt;
    next_line_cnt  = line_cnt;
    next_frame_cnt = frame_cnt;
    next_prs_pixel = prs_pixel;
    next_prs_line  = prs_line;
    next_red_on    = out_red_on;
    next_green_on  = out_green_on;
    next_blue_on   = out_blue_on;
    // position and randomisation as seen by the pixel at the head
    px             = sof || sol ? 3'd0 : col_cnt;                                 // R19
    py             = sof ? 3'd0 : (sol ? 3'(line_cnt + 1'b1) : line_cnt);        // R19
    phase          = sof ? 6'(frame_cnt + 1'b1) : frame_cnt;
    // a stalled or stale head must not reseed or step the line register
    if (fifo_take && sof) begin
      next_prs_pixel = 15'h0001;                                                 // R21
      next_prs_line  = 9'h001;                                                   // R21
    end else if (fifo_take && sol) begin
      next_prs_line  = {prs_line[7:0], prs_line[8] ^ prs_line[4]};
    end
    pos = 6'(phase + next_prs_pixel[5:0] + next_prs_line[5:0]);                  // R20
    case (out_state)
      FDT_OUT_IDLE: if (fifo_take) next_out_state = FDT_OUT_FULL;
      FDT_OUT_FULL: if (out_ready && !fifo_take) next_out_state = FDT_OUT_IDLE;
      default:      next_out_state = FDT_OUT_IDLE;
    endcase
    if (fifo_take) begin
      // frame modulation is applied to every pixel, dithered or not  R10
      next_red_on    = table_red[fdt_row(fifo_data[3*COMP_W-1 -: COMP_W], dith_on,
                                         dbits, px, py)][pos];                   // R20
      next_green_on  = table_green[fdt_row(fifo_data[2*COMP_W-1 -: COMP_W], dith_on,
                                           dbits, px, py)][pos];
      next_blue_on   = table_blue[fdt_row(fifo_data[COMP_W-1:0], dith_on,
                                          dbits, px, py)][pos];
      next_col_cnt   = 3'(px + 1'b1);                                            // R19
      next_line_cnt  = py;
      next_frame_cnt = phase;
      next_prs_pixel = {next_prs_pixel[13:0],
                        next_prs_pixel[14] ^ next_prs_pixel[13]};
    end
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      out_state    <= FDT_OUT_IDLE;
      col_cnt      <= 3'd0;
      line_cnt     <= 3'd0;
      frame_cnt    <= 6'd0;
      prs_pixel    <= 15'h0001;
      prs_line     <= 9'h001;
      out_valid    <= 1'b0;
      out_red_on   <= 1'b0;
      out_green_on <= 1'b0;
      out_blue_on  <= 1'b0;
    end else begin
      out_state    <= next_out_state;
      col_cnt      <= next_col_cnt;
      line_cnt     <= next_line_cnt;
      frame_cnt    <= next_frame_cnt;
      prs_pixel    <= next_prs_pixel;
      prs_line     <= next_prs_line;
      out_valid    <= next_out_state == FDT_OUT_FULL;
      out_red_on   <= next_red_on;
      out_green_on <= next_green_on;
      out_blue_on  <= next_blue_on;
    end
  end

endmodule : fdt_top

// ===== verif/fdt_top_checker.sv
`timescale 1ns/1ps
`include "fdt_cfg.svh"
module fdt_top_checker (
  // clock and reset
  input wire logic        clock,
  input wire logic        rst_n,
  // register port
  input wire logic        reg_strobe,
  input wire logic        reg_write,
  input wire logic [11:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic [31:0] reg_rdata,
  input wire logic        reg_rvalid,
  // output stream and power hint
  input wire logic        out_valid,
  input wire logic        out_ready,
  input wire logic        out_red_on,
  input wire logic        out_green_on,
  input wire logic        out_blue_on,
  input wire logic        dither_ram_low_power
);
  logic       rd;
  logic       wr;
  logic       exp_lp;
  logic       src_bit;
  logic       next_src_bit;
  logic [1:0] ram_sel;
  logic [1:0] next_ram_sel;
  logic       mapped;
  assign rd = reg_strobe && !reg_write;
  assign wr = reg_strobe && reg_write;
  assign exp_lp = !src_bit && ram_sel == 2'h0;
  assign mapped = reg_addr inside {`FDT_OFS_DITHER_CTRL, `FDT_OFS_TABLE_INDEX,
                                   `FDT_OFS_TABLE_DATA, `FDT_OFS_DITHER_RAM};
  // shadow of the two fields that decide the pattern RAM power state
  always_comb begin
    next_src_bit = src_bit;
    next_ram_sel = ram_sel;
    if (wr && reg_addr == `FDT_OFS_DITHER_CTRL) next_src_bit = reg_wdata[12];
    if (wr && reg_addr == `FDT_OFS_DITHER_RAM) next_ram_sel = reg_wdata[7:6];
  end
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      src_bit <= 1'b0;
      ram_sel <= 2'h0;
    end else begin
      src_bit <= next_src_bit;
      ram_sel <= next_ram_sel;
    end
  end
  default clocking @(posedge clock); endclocking
  default disable iff (!rst_n);
  property p_read_answer;
    rd |=> reg_rvalid;
  endproperty
  a_read_answer: assert property (p_read_answer) else $error("read got no answer");
  property p_no_stray_answer;
    !rd |=> !reg_rvalid;
  endproperty
  a_no_stray_answer: assert property (p_no_stray_answer) else $error("stray read answer");
  property p_rdata_hold;
    !reg_rvalid |-> $stable(reg_rdata);
  endproperty
  a_rdata_hold: assert property (p_rdata_hold) else $error("read data moved");
  property p_unmapped_zero;
    rd && !mapped |=> reg_rdata == 32'h0;
  endproperty
  a_unmapped_zero: assert property (p_unmapped_zero) else $error("unmapped read nonzero");
  property p_index_readback;
    wr && reg_addr == `FDT_OFS_TABLE_INDEX ##1 rd && reg_addr == `FDT_OFS_TABLE_INDEX
      |=> reg_rdata[9:0] == ($past(reg_wdata[9:0], 2) & 10'h33f);
  endproperty
  a_index_readback: assert property (p_index_readback) else $error("index readback");
  property p_index_advance;
    wr && reg_addr == `FDT_OFS_TABLE_INDEX ##1 reg_strobe && reg_addr == `FDT_OFS_TABLE_DATA
      ##1 rd && reg_addr == `FDT_OFS_TABLE_INDEX
      |=> reg_rdata[5:0] == 6'($past(reg_wdata[5:0], 3) + 6'h01);
  endproperty
  a_index_advance: assert property (p_index_advance) else $error("index did not advance");
  property p_out_hold;
    out_valid && !out_ready
      |=> out_valid && $stable({out_red_on, out_green_on, out_blue_on});
  endproperty
  a_out_hold: assert property (p_out_hold) else $error("output dropped while stalled");
  property p_low_power;
    exp_lp == $past(exp_lp) |-> dither_ram_low_power == exp_lp;
  endproperty
  a_low_power: assert property (p_low_power) else $error("pattern RAM power state");
endmodule : fdt_top_checker

bind fdt_top fdt_top_checker i_checker (.clock(clock), .rst_n(rst_n), .reg_strobe(reg_strobe),
  .reg_write(reg_write), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
  .reg_rvalid(reg_rvalid), .out_valid(out_valid), .out_ready(out_ready),
  .out_red_on(out_red_on), .out_green_on(out_green_on), .out_blue_on(out_blue_on),
  .dither_ram_low_power(dither_ram_low_power));

// ===== verif/fdt_pix_source.sv
`timescale 1ns/1ps
module fdt_pix_source (
  // clock
  input wire logic  clock,
  // pixel stream toward the block
  output logic       pix_valid,
  input wire logic   pix_ready,
  output logic       pix_frame_start,
  output logic       pix_line_start,
  output logic [5:0] pix_red,
  output logic [5:0] pix_green,
  output logic [5:0] pix_blue
);
  initial begin
    pix_valid = 1'b0;
    pix_frame_start = 1'b0;
    pix_line_start = 1'b0;
    {pix_red, pix_green, pix_blue} = 18'h2a2a5;
  end
  // one 8x8 tile of equal pixels; idle lines carry the inverse so stale data never matches
  task automatic send_frame(input logic [5:0] value, input logic slow);
    for (int k = 0; k < 64; k++) begin
      if (slow) begin
        @(negedge clock);
        pix_valid = 1'b0;
        {pix_red, pix_green, pix_blue} = {3{~value}};
      end
      @(negedge clock);
      pix_valid = 1'b1;
      pix_frame_start = (k == 0);
      pix_line_start = (k % 8 == 0) && (k != 0);
      {pix_red, pix_green, pix_blue} = {3{value}};
      do @(posedge clock); while (pix_ready !== 1'b1);
    end
    @(negedge clock);
    pix_valid = 1'b0;
    pix_frame_start = 1'b0;
    pix_line_start = 1'b0;
    {pix_red, pix_green, pix_blue} = {3{~value}};
  endtask : send_frame
endmodule : fdt_pix_source

// ===== verif/frm_table_access_and_dither_test.sv
`timescale 1ns/1ps
`include "fdt_cfg.svh"
`define CHECK(got, exp) begin total_checks++; if ((got) !== (exp)) begin num_errors++; \
  $display("MISMATCH at %0t got %h expected %h", $time, (got), (exp)); end end
module frm_table_access_and_dither_test;
  logic        clock = 1'b0;
  logic        rst_n = 1'b0;
  logic        reg_strobe = 1'b0;
  logic        reg_write = 1'b0;
  logic [11:0] reg_addr = 12'h0;
  logic [31:0] reg_wdata = 32'h0;
  logic [31:0] reg_rdata;
  logic        reg_rvalid;
  logic        pix_valid, pix_ready, pix_frame_start, pix_line_start;
  logic [5:0]  pix_red, pix_green, pix_blue;
  logic        out_valid, out_red_on, out_green_on, out_blue_on, dither_ram_low_power;
  logic        out_ready = 1'b0;
  logic        hold = 1'b0;
  logic        stall = 1'b0;
  logic [1:0]  phase = 2'h0;
  int          num_errors = 0;
  int          total_checks = 0;
  int          cycles = 0;
  int          rx, lit_r, lit_g, lit_b;

  fdt_top i_dut (.clock(clock), .rst_n(rst_n), .reg_strobe(reg_strobe), .reg_write(reg_write),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid),
    .pix_valid(pix_valid), .pix_ready(pix_ready), .pix_frame_start(pix_frame_start),
    .pix_line_start(pix_line_start), .pix_red(pix_red), .pix_green(pix_green),
    .pix_blue(pix_blue), .out_valid(out_valid), .out_ready(out_ready),
    .out_red_on(out_red_on), .out_green_on(out_green_on), .out_blue_on(out_blue_on),
    .dither_ram_low_power(dither_ram_low_power));
  fdt_pix_source i_src (.clock(clock), .pix_valid(pix_valid), .pix_ready(pix_ready),
    .pix_frame_start(pix_frame_start), .pix_line_start(pix_line_start), .pix_red(pix_red),
    .pix_green(pix_green), .pix_blue(pix_blue));

  always #5 clock = ~clock;
  // consumer stalls every other cycle when asked, so held outputs get exercised
  always @(negedge clock) begin
    phase <= phase + 2'h1;
    out_ready <= !hold && (!stall || phase[0]);
  end
  always @(posedge clock) begin
    cycles++;
    if (out_valid === 1'b1 && out_ready === 1'b1) begin
      `CHECK($isunknown({out_red_on, out_green_on, out_blue_on}), 1'b0)
      rx++;
      lit_r += out_red_on;
      lit_g += out_green_on;
      lit_b += out_blue_on;
    end
    if (cycles == 30000) begin
      num_errors++;
      complete_run();
    end
  end

  task automatic complete_run;
    if (num_errors == 0 && total_checks > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask : complete_run
  // writes leave the strobe up so a following access is back to back
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    @(negedge clock);
    {reg_strobe, reg_write, reg_addr, reg_wdata} = {2'b11, a, d};
  endtask : wr
  task automatic idle;
    @(negedge clock);
    reg_strobe = 1'b0;
  endtask : idle
  task automatic rd(input logic [11:0] a, input logic [31:0] exp);
    @(negedge clock);
    {reg_strobe, reg_write, reg_addr} = {2'b10, a};
    @(negedge clock);
    reg_strobe = 1'b0;
    `CHECK(reg_rvalid, 1'b1)
    `CHECK(reg_rdata, exp)
  endtask : rd
  task automatic load_row(input logic [1:0] sel, input logic [4:0] row, input logic [63:0] w);
    wr(`FDT_OFS_TABLE_INDEX, {22'h0, sel, 2'h0, row, 1'b0});
    wr(`FDT_OFS_TABLE_DATA, w[31:0]);
    wr(`FDT_OFS_TABLE_DATA, w[63:32]);
    idle();
  endtask : load_row
  task automatic run_frame(input logic [5:0] value, input logic slow, input logic block,
                           input int er, input int eg, input int eb);
    {rx, lit_r, lit_g, lit_b} = '0;
    if (block) begin
      hold = 1'b1;
      fork
        i_src.send_frame(value, slow);
      join_none
      repeat (40) @(negedge clock);
      `CHECK(pix_ready, 1'b0)
      `CHECK(out_valid, 1'b1)
      hold = 1'b0;
      wait fork;
    end else begin
      i_src.send_frame(value, slow);
    end
    for (int i = 0; i < 300 && rx < 64; i++) @(negedge clock);
    `CHECK(rx, 64)
    `CHECK(lit_r, er)
    `CHECK(lit_g, eg)
    `CHECK(lit_b, eb)
  endtask : run_frame

  task automatic test_reset;
    `CHECK(dither_ram_low_power, 1'b1)
    `CHECK(pix_ready, 1'b1)
    `CHECK(out_valid, 1'b0)
    rd(`FDT_OFS_TABLE_INDEX, 32'h0);
    rd(12'h400, 32'h0);
  endtask : test_reset
  task automatic test_table_access;
    load_row(2'h1, 5'd0, 64'h2222_0002_1111_0001);
    load_row(2'h2, 5'd0, 64'h4444_0004_3333_0003);
    load_row(2'h3, 5'd0, 64'h6666_0006_5555_0005);
    wr(`FDT_OFS_TABLE_INDEX, 32'h0);
    rd(`FDT_OFS_TABLE_DATA, 32'h1111_0001);
    rd(`FDT_OFS_TABLE_DATA, 32'h2222_0002);
    wr(`FDT_OFS_TABLE_INDEX, 32'h200);
    rd(`FDT_OFS_TABLE_DATA, 32'h3333_0003);
    wr(`FDT_OFS_TABLE_INDEX, 32'h301);
    rd(`FDT_OFS_TABLE_INDEX, 32'h301);
    rd(`FDT_OFS_TABLE_DATA, 32'h6666_0006);
    wr(`FDT_OFS_TABLE_INDEX, 32'h03f);
    wr(`FDT_OFS_TABLE_DATA, 32'h7777_0007);
    rd(`FDT_OFS_TABLE_INDEX, 32'h0);
    wr(`FDT_OFS_TABLE_INDEX, 32'h23f);
    rd(`FDT_OFS_TABLE_DATA, 32'h7777_0007);
    wr(`FDT_OFS_TABLE_INDEX, 32'h33f);
    rd(`FDT_OFS_TABLE_DATA, 32'h7777_0007);
  endtask : test_table_access
  task automatic test_modulation;
    load_row(2'h0, 5'd0, 64'h0);
    load_row(2'h0, 5'd1, '1);
    wr(`FDT_OFS_DITHER_CTRL, 32'h44);
    idle();
    stall = 1'b1;
    run_frame(6'h02, 1'b1, 1'b0, 64, 64, 64);
    stall = 1'b0;
    run_frame(6'h00, 1'b0, 1'b0, 0, 0, 0);
    load_row(2'h3, 5'd1, 64'h0);
    run_frame(6'h02, 1'b0, 1'b0, 64, 64, 0);
    load_row(2'h2, 5'd1, 64'h0);
    run_frame(6'h02, 1'b0, 1'b1, 64, 0, 0);
    load_row(2'h0, 5'd1, '1);
  endtask : test_modulation
  task automatic test_dither;
    int exp;
    logic [5:0] low;
    for (int n = 1; n <= 5; n++) begin
      wr(`FDT_OFS_DITHER_CTRL, 32'((6 - n) << 4 | n << 1 | 1));
      idle();
      for (int j = 0; j < 3; j++) begin
        low = (j == 0) ? 6'h0 : (j == 1) ? 6'h1 : 6'((1 << n) - 1);
        exp = 64 * (low + 1) >> n;
        run_frame(6'((1 << n) | low), 1'b0, 1'b0, exp, exp, exp);
      end
    end
  endtask : test_dither
  task automatic test_low_power;
    wr(`FDT_OFS_DITHER_CTRL, 32'h1000);
    idle();
    repeat (3) @(negedge clock);
    `CHECK(dither_ram_low_power, 1'b0)
    wr(`FDT_OFS_DITHER_CTRL, 32'h0);
    wr(`FDT_OFS_DITHER_RAM, 32'h40);
    idle();
    repeat (3) @(negedge clock);
    `CHECK(dither_ram_low_power, 1'b0)
    wr(`FDT_OFS_DITHER_RAM, 32'h3f);
    idle();
    repeat (3) @(negedge clock);
    `CHECK(dither_ram_low_power, 1'b1)
  endtask : test_low_power

  initial begin
    repeat (6) @(negedge clock);
    rst_n = 1'b1;
    test_reset();
    test_table_access();
    test_modulation();
    test_dither();
    test_low_power();
    complete_run();
  end
endmodule : frm_table_access_and_dither_test
